// File: sim/adcfmt_asserts.sv
// checker of sequencing, port read and read formats
`timescale 1ns/10ps
module adcfmt_chk import adcfmt_pkg::*; #(parameter int NUM_PINS = 16, parameter int BUF_AW = 4) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CONV_ON,
  input wire logic CONV_START,
  input wire logic CPU_IDLE,
  input wire logic STOP_IN_IDLE,
  input wire logic [NUM_PINS-1:0] ANALOG_PIN_CONFIG,
  input wire logic [NUM_PINS-1:0] PIN_IN_LEVEL,
  input wire logic [NUM_PINS-1:0] PORT_READ,
  input wire logic [FMT_W-1:0] OUTPUT_FORMAT_SEL,
  input wire logic [BUS_W-1:0] BUF_RD_DATA,
  input wire logic CONV_BUSY,
  input wire logic CONV_DONE,
  input wire logic [BUF_AW-1:0] RESULT_PTR
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic halt = CPU_IDLE && STOP_IN_IDLE;
  start_take_a: assert property (CONV_START && CONV_ON && !halt && !CONV_BUSY |=> CONV_BUSY)
    else $error("start not taken");
  done_len_a: assert property (CONV_DONE |-> $past(CONV_BUSY, 15) && !$past(CONV_BUSY, 16))
    else $error("done at wrong time");
  abort_off_a: assert property (CONV_BUSY && !CONV_ON |=> !CONV_BUSY && !CONV_DONE)
    else $error("off did not abort");
  idle_halt_a: assert property (CONV_BUSY && halt |=> !CONV_BUSY && !CONV_DONE)
    else $error("idle did not halt");
  idle_run_a: assert property (CONV_BUSY && CONV_ON && !halt |=> CONV_BUSY || CONV_DONE)
    else $error("sequence dropped");
  ptr_step_a: assert property ($past(RST_N) |-> RESULT_PTR == $past(RESULT_PTR) + BUF_AW'(CONV_DONE))
    else $error("pointer step wrong");
  port_zero_a: assert property ($past(RST_N) |-> PORT_READ == $past(PIN_IN_LEVEL & ~ANALOG_PIN_CONFIG))
    else $error("port read wrong");
  fmt_int_a: assert property ($past(RST_N) && $past(OUTPUT_FORMAT_SEL) == FMT_UINT |-> BUF_RD_DATA[15:12] == PAD_ZERO)
    else $error("integer pad wrong");
  fmt_frac_a: assert property ($past(RST_N) && $past(OUTPUT_FORMAT_SEL[1]) |-> BUF_RD_DATA[3:0] == PAD_ZERO)
    else $error("fraction pad wrong");
  fmt_sint_a: assert property ($past(RST_N) && $past(OUTPUT_FORMAT_SEL) == FMT_SINT
    |-> BUF_RD_DATA[15:12] == {4{BUF_RD_DATA[11]}}) else $error("sign extension wrong");
endmodule : adcfmt_chk
bind adcfmt_top adcfmt_chk #(.NUM_PINS(NUM_PINS), .BUF_AW(BUF_AW)) chk_u (.*);

// File: sim/tb.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module tb;
  import adcfmt_pkg::*;
  logic SYS_CLK = 0, RST_N = 0, CONV_ON = 1, CONV_START = 0, CPU_IDLE = 0, STOP_IN_IDLE = 0, BUF_WR_EN = 0;
  logic [3:0] CHAN0_POS_SELECT_A = 0, BUF_WR_ADDR = 0, BUF_RD_ADDR = 0, RESULT_PTR, p;
  logic [15:0] ANALOG_PIN_CONFIG = 0, PIN_DIRECTION = 0, PIN_OUT_LEVEL = 0, PIN_IN_LEVEL = 0;
  logic [15:0] BUF_WR_DATA = 0, BUF_RD_DATA, PORT_READ, w;
  logic [11:0] ANALOG_SAMPLE = 0, e;
  logic [1:0] OUTPUT_FORMAT_SEL = 0;
  logic CONV_BUSY, CONV_DONE, dn;
  logic [31:0] seed = 32'h5e83_2672;
  int err_total = 0, n_checks = 0, cyc = 0;
  adcfmt_top dut_u (.*);
  initial forever #2.5 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      results();
    end
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [15:0] fmt(logic [11:0] d, logic [1:0] f);
    logic [11:0] v;
    v = {~d[11], d[10:0]};
    case (f)
      FMT_UINT: return {PAD_ZERO, d};
      FMT_SINT: return {{4{v[11]}}, v};
      FMT_UFRAC: return {d, PAD_ZERO};
      default: return {v, PAD_ZERO};
    endcase
  endfunction : fmt
  task chk(input logic [15:0] g, x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge SYS_CLK) {BUF_WR_EN, BUF_WR_ADDR, BUF_WR_DATA} <= {1'b1, a, d};
    @(negedge SYS_CLK) BUF_WR_EN <= 0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [1:0] f);
    @(negedge SYS_CLK) {BUF_RD_ADDR, OUTPUT_FORMAT_SEL} <= {a, f};
    repeat (2) @(negedge SYS_CLK);
  endtask : rd
  task results();
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // k: 0 clean, 1 off, 2 idle stop, 3 reset, 4 idle run
  task run(input int k);
    logic [3:0] s;
    logic ok;
    p = RESULT_PTR;
    w = 16'(rnd());
    wr(p, w);
    {ANALOG_PIN_CONFIG, PIN_DIRECTION} = rnd();
    {PIN_OUT_LEVEL, PIN_IN_LEVEL} = rnd();
    CHAN0_POS_SELECT_A = 4'(rnd());
    ANALOG_SAMPLE = 12'(rnd());
    if (k == 4) PIN_DIRECTION = PIN_DIRECTION | ANALOG_PIN_CONFIG;
    s = CHAN0_POS_SELECT_A;
    e = !ANALOG_PIN_CONFIG[s] ? RES_ZERO : !PIN_DIRECTION[s] ? {12{PIN_OUT_LEVEL[s]}} : ANALOG_SAMPLE;
    ok = k == 0 || k == 4;
    CONV_START <= 1;
    @(negedge SYS_CLK) CONV_START <= 0;
    chk(PORT_READ, PIN_IN_LEVEL & ~ANALOG_PIN_CONFIG);
    chk({15'h0, CONV_BUSY}, 16'h0001);
    dn = 0;
    for (int i = 0; i < 20; i++) begin
      @(negedge SYS_CLK);
      dn |= CONV_DONE;
      if (i == 4) case (k)
        1: CONV_ON <= 0;
        2: {CPU_IDLE, STOP_IN_IDLE} <= 2'b11;
        3: RST_N <= 0;
        4: CPU_IDLE <= 1;
      endcase
      if (i == 5) {RST_N, CONV_ON, CPU_IDLE, STOP_IN_IDLE} <= 4'b1100;
      // start while busy is ignored
      if (i == 6 || i == 7) CONV_START <= (i == 6) && (k == 0);
    end
    chk({15'h0, dn}, {15'h0, ok});
    chk({12'h0, RESULT_PTR}, {12'h0, (k == 3) ? 4'h0 : p + 4'(ok)});
    rd(p, FMT_UINT);
    chk(BUF_RD_DATA, {PAD_ZERO, ok ? e : w[11:0]});
  endtask : run
  initial begin
    repeat (8) @(negedge SYS_CLK);
    RST_N = 1;
    for (int i = 0; i < 16; i++) begin
      w = i == 0 ? 16'hf800 : i == 1 ? 16'h07ff : 16'(rnd());
      wr(4'(i), w);
      for (int f = 0; f < 4; f++) begin
        rd(4'(i), 2'(f));
        chk(BUF_RD_DATA, fmt(w[11:0], 2'(f)));
      end
    end
    for (int i = 0; i < 25; i++) run(i % 5);
    results();
  end
endmodule : tb

// File: verilog/adcfmt_format.sv
// package of shared constants and the read-format translator
`timescale 1ns/10ps
package adcfmt_pkg;
  localparam int RES_W = 12;
  localparam int BUS_W = 16;
  localparam int PAD_W = BUS_W - RES_W;
  localparam int SEL_W = 4;
  localparam int FMT_W = 2;
  localparam logic [FMT_W-1:0] FMT_UINT = 2'h0;
  localparam logic [FMT_W-1:0] FMT_SINT = 2'h1;
  localparam logic [FMT_W-1:0] FMT_UFRAC = 2'h2;
  localparam logic [FMT_W-1:0] FMT_SFRAC = 2'h3;
  localparam logic [PAD_W-1:0] PAD_ZERO = 4'h0;
  localparam logic [PAD_W-1:0] PAD_ONES = 4'hf;
  localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
  localparam logic [RES_W-1:0] RES_FULL = 12'hfff;
  localparam logic [BUS_W-1:0] BUS_ZERO = 16'h0000;
  localparam int MSB = RES_W - 1;
  // sample and conversion lengths in converter clocks
  localparam int SAMPLE_CLKS = 1;
  localparam int CONV_CLKS = 14;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_SAMPLE = 2'h1,
    ST_CONVERT = 2'h3
  } adcfmt_state_t;
endpackage : adcfmt_pkg

module adcfmt_format (
  input wire logic [adcfmt_pkg::FMT_W-1:0] output_format_sel,
  input wire logic [adcfmt_pkg::RES_W-1:0] raw,
  output logic [adcfmt_pkg::BUS_W-1:0] bus_word
);
  import adcfmt_pkg::*;
  logic [RES_W-1:0] offset_val;

  always_comb begin
    offset_val = {~raw[MSB], raw[MSB-1:0]};
    case (output_format_sel)
      FMT_UINT: bus_word = {PAD_ZERO, raw};
      FMT_SINT: bus_word = {(offset_val[MSB] ? PAD_ONES : PAD_ZERO), offset_val};
      FMT_UFRAC: bus_word = {raw, PAD_ZERO};
      FMT_SFRAC: bus_word = {offset_val, PAD_ZERO};
      default: bus_word = BUS_ZERO;
    endcase
  end
endmodule : adcfmt_format

// File: verilog/adcfmt_top.sv
// converter sequencing, result buffer, read formats and port read
// ============================================================
`timescale 1ns/10ps
module adcfmt_top #(
  parameter int NUM_PINS = 16,
  parameter int BUF_DEPTH = 16,
  parameter int BUF_AW = 4
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic CONV_ON,
  input wire logic CONV_START,
  input wire logic CPU_IDLE,
  input wire logic STOP_IN_IDLE,
  input wire logic [adcfmt_pkg::SEL_W-1:0] CHAN0_POS_SELECT_A,
  input wire logic [NUM_PINS-1:0] ANALOG_PIN_CONFIG,
  input wire logic [NUM_PINS-1:0] PIN_DIRECTION,
  input wire logic [NUM_PINS-1:0] PIN_OUT_LEVEL,
  input wire logic [NUM_PINS-1:0] PIN_IN_LEVEL,
  input wire logic [adcfmt_pkg::RES_W-1:0] ANALOG_SAMPLE,
  input wire logic [adcfmt_pkg::FMT_W-1:0] OUTPUT_FORMAT_SEL,
  input wire logic BUF_WR_EN,
  input wire logic [BUF_AW-1:0] BUF_WR_ADDR,
  input wire logic [adcfmt_pkg::BUS_W-1:0] BUF_WR_DATA,
  input wire logic [BUF_AW-1:0] BUF_RD_ADDR,
  output logic [adcfmt_pkg::BUS_W-1:0] BUF_RD_DATA,
  output logic [NUM_PINS-1:0] PORT_READ,
  output logic CONV_BUSY,
  output logic CONV_DONE,
  output logic [BUF_AW-1:0] RESULT_PTR
);
  import adcfmt_pkg::*;

  // ============================================================
  // converter sequencer
  adcfmt_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [RES_W-1:0] hold_q, hold_d;
  logic [BUF_AW-1:0] ptr_q, ptr_d;
  logic done_q, done_d;
  logic busy_q, busy_d;
  logic halt;
  logic [RES_W-1:0] pin_value;
  logic result_wr;

  assign halt = ~CONV_ON | (CPU_IDLE & STOP_IN_IDLE);

  always_comb begin
    // acquisition path, no dependence on gating
    pin_value = ANALOG_SAMPLE;
    if (!ANALOG_PIN_CONFIG[CHAN0_POS_SELECT_A]) begin
      // digital input gives no analog level
      pin_value = RES_ZERO;
    end else if (!PIN_DIRECTION[CHAN0_POS_SELECT_A]) begin
      pin_value = PIN_OUT_LEVEL[CHAN0_POS_SELECT_A] ? RES_FULL : RES_ZERO;
    end
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    ptr_d = ptr_q;
    done_d = 1'b0;
    result_wr = 1'b0;
    case (state_q)
      ST_OFF: begin
        if (!halt && CONV_START) begin
          state_d = ST_SAMPLE;
          cnt_d = CNT_W'(SAMPLE_CLKS);
        end
      end
      ST_SAMPLE: begin
        if (halt) begin
          state_d = ST_OFF;
        end else if (cnt_q == CNT_ONE) begin
          state_d = ST_CONVERT;
          cnt_d = CNT_W'(CONV_CLKS);
          hold_d = pin_value;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      ST_CONVERT: begin
        if (halt) begin
          // aborted conversion never reaches the buffer
          state_d = ST_OFF;
        end else if (cnt_q == CNT_ONE) begin
          state_d = ST_OFF;
          result_wr = 1'b1;
          done_d = 1'b1;
          ptr_d = ptr_q + {{(BUF_AW-1){1'b0}}, 1'b1};
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    busy_d = (state_d != ST_OFF);
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_OFF;
      cnt_q <= CNT_ZERO;
      hold_q <= RES_ZERO;
      ptr_q <= {BUF_AW{1'b0}};
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      ptr_q <= ptr_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  // ============================================================
  // result buffer
  // twelve-bit entries
  logic [RES_W-1:0] buf_q [BUF_DEPTH];
  logic [RES_W-1:0] buf_d [BUF_DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_entry
      always_comb begin
        buf_d[gi] = buf_q[gi];
        if (BUF_WR_EN && (BUF_WR_ADDR == BUF_AW'(gi))) begin
          buf_d[gi] = BUF_WR_DATA[RES_W-1:0];
        end else if (result_wr && (ptr_q == BUF_AW'(gi))) begin
          buf_d[gi] = hold_q;
        end
      end

      always_ff @(posedge SYS_CLK) begin
        buf_q[gi] <= buf_d[gi];
      end
    end
  endgenerate

  // ============================================================
  // read path and port read
  logic [BUS_W-1:0] fmt_word;
  logic [BUS_W-1:0] rd_q, rd_d;
  logic [NUM_PINS-1:0] port_q, port_d;

  adcfmt_format u_format (
    .output_format_sel(OUTPUT_FORMAT_SEL),
    .raw(buf_q[BUF_RD_ADDR]),
    .bus_word(fmt_word)
  );

  always_comb begin
    rd_d = fmt_word;
    port_d = PIN_IN_LEVEL & ~ANALOG_PIN_CONFIG;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_q <= BUS_ZERO;
      port_q <= {NUM_PINS{1'b0}};
    end else begin
      rd_q <= rd_d;
      port_q <= port_d;
    end
  end

  assign BUF_RD_DATA = rd_q;
  assign PORT_READ = port_q;
  assign CONV_BUSY = busy_q;
  assign CONV_DONE = done_q;
  assign RESULT_PTR = ptr_q;
endmodule : adcfmt_top
